/* ext_mem_pkg.sv */
// Purpose: shared constants for the external memory phase timing block
// Assumes: 32-bit register port, byte addresses, one word per register
// Notes:   zone register i sits at OFF_ZONE_BASE + i * ZONE_STRIDE
package ext_mem_pkg;
    // ------------------------------------------------------------
    // bus and counter widths
    // ------------------------------------------------------------
    localparam int BUS_AW = 8;
    localparam int BUS_DW = 32;
    localparam int ZIDX_W = 2;
    localparam int LEN_W  = 4;
    localparam int WS_W   = 8;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [BUS_AW-1:0] OFF_ZONE_BASE = 8'h00;
    localparam logic [BUS_AW-1:0] ZONE_STRIDE   = 8'h04;
    localparam logic [BUS_AW-1:0] OFF_CLKCFG    = 8'h0c;
    localparam logic [BUS_AW-1:0] OFF_STATUS    = 8'h10;

    // ------------------------------------------------------------
    // zone timing register fields
    // ------------------------------------------------------------
    localparam int LEAD_W        = 2;
    localparam int ACT_W         = 3;
    localparam int TRAIL_W       = 2;
    localparam int WR_LEAD_LSB   = 0;
    localparam int WR_ACT_LSB    = 2;
    localparam int WR_TRAIL_LSB  = 5;
    localparam int RDY_EN_BIT    = 7;
    localparam int RDY_ASYNC_BIT = 8;
    localparam int RD_LEAD_LSB   = 9;
    localparam int RD_ACT_LSB    = 11;
    localparam int RD_TRAIL_LSB  = 14;
    localparam int DBL_BIT       = 16;
    localparam int CFG_W         = 17;
    localparam logic [CFG_W-1:0] TIMING_RST = 17'h1fe7f;

    // ------------------------------------------------------------
    // status fields and clock ratio modes
    // ------------------------------------------------------------
    localparam int ST_BUSY_BIT  = 0;
    localparam int ST_PHASE_LSB = 1;
    localparam int ST_WS_LSB    = 8;
    localparam int CLKCFG_W     = 2;

    typedef enum logic [CLKCFG_W-1:0] {
        CLK_M1, CLK_M2, CLK_M3, CLK_M4
    } clk_mode_e;
    localparam clk_mode_e CLK_MODE_RST = CLK_M3;
endpackage

/* clk_ratio_gen.sv */
// Purpose: timing clock enable and output clock for the four ratios
// Assumes: mode is changed only while no access runs
// Notes:   out_rise always falls on a tick
`timescale 1ns/1ns
module clk_ratio_gen (
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst,
    // ratio select
    input  wire ext_mem_pkg::clk_mode_e mode,
    // enables and pin level
    output logic                       tick,
    output logic                       out_rise,
    output logic                       clk_out
);
    import ext_mem_pkg::*;

    logic [1:0] cnt;
    logic [1:0] last;
    logic [1:0] next_cnt;
    logic       tim_half;

    always_comb begin
        tim_half = (mode == CLK_M3) || (mode == CLK_M4);
        unique case (mode)
            CLK_M1:         last = 2'h0;
            CLK_M2, CLK_M3: last = 2'h1;
            CLK_M4:         last = 2'h3;
        endcase
        next_cnt = (cnt >= last) ? 2'h0 : cnt + 2'h1;
    end

    // in ratio 1 the pin cannot toggle at the system rate; it stays high
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt      <= 2'h0;
            tick     <= 1'b0;
            out_rise <= 1'b0;
            clk_out  <= 1'b0;
        end else begin
            cnt      <= next_cnt;
            tick     <= tim_half ? !next_cnt[0] : 1'b1;
            out_rise <= (next_cnt == 2'h0);
            // pin rises on the same edge at which strobes may move
            clk_out  <= (last == 2'h0) || (cnt <= (last >> 1));
        end
    end

    AST_HALF_TICK: assert property (
        @(posedge clk) disable iff (rst)
        (mode == CLK_M3 || mode == CLK_M4) && $stable(mode) && tick
        |=> !tick)
        else $error("timing tick ran at full rate in a half mode");

    AST_RISE_ON_TICK: assert property (
        @(posedge clk) disable iff (rst)
        out_rise |-> tick)
        else $error("output clock rise without a timing tick");
endmodule

/* ready_sync.sv */
// Purpose: brings the external ready pin into the clock domain
// Assumes: pin is fully asynchronous to clk
// Notes:   async mode adds a stage for extra settling margin
`timescale 1ns/1ns
module ready_sync (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // pin and mode
    input  wire logic ready_pin,
    input  wire logic async_mode,
    // synchronised level
    output logic      ready_s
);
    logic stage1;
    logic stage2;
    logic stage3;

    always_ff @(posedge clk) begin
        if (rst) begin
            stage1 <= 1'b1;
            stage2 <= 1'b1;
            stage3 <= 1'b1;
        end else begin
            stage1 <= ready_pin;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    assign ready_s = async_mode ? stage3 : stage2;
endmodule

/* ext_mem_phase_timing.sv */
// Purpose: lead/active/trail strobe timing for a zoned memory interface
// Assumes: one access at a time, requested on the access port
// Notes:   strobes and address are registered pins
//
// How it works
// - each access runs lead, active, trail
// - one timing register per zone, applied
// - phases counted in timing clock ticks
// - read lead is count, doubled if selected
// - read active is count+waits+1, count doubled if selected
// - read trail is count, doubled if selected
// - writes use write counts, same formulas
// - illegal settings applied as written, unchecked
// - ready disabled means zero wait states
// - four timing and output clock ratios
// - strobes switch only on timing ticks
// - lead starts on output clock rise, aligned
// - address held during idle and alignment
//
// Added by the designer: the register offsets and strobed register access.
`timescale 1ns/1ns
module ext_mem_phase_timing #(
    parameter int ZONES = 3,
    parameter int XA_W  = 19
) (
    // clock and reset
    input  wire logic                          clk,
    input  wire logic                          rst,
    // register port
    input  wire logic [ext_mem_pkg::BUS_AW-1:0] reg_addr,
    input  wire logic [ext_mem_pkg::BUS_DW-1:0] reg_wdata,
    input  wire logic                          reg_wr,
    input  wire logic                          reg_rd,
    output logic [ext_mem_pkg::BUS_DW-1:0]     reg_rdata,
    // access request port
    input  wire logic                          acc_req,
    input  wire logic                          acc_write,
    input  wire logic [ext_mem_pkg::ZIDX_W-1:0] acc_zone,
    input  wire logic [XA_W-1:0]               acc_addr,
    output logic                               acc_busy,
    output logic                               acc_done,
    // external pins
    input  wire logic                          external_ready_input,
    output logic                               external_clock_output,
    output logic                               read_strobe_n,
    output logic                               write_strobe_n,
    output logic [ZONES-1:0]                   zone_select_n,
    output logic [XA_W-1:0]                    ext_addr
);
    import ext_mem_pkg::*;
    typedef enum logic [2:0] {
        ST_IDLE, ST_ALIGN, ST_LEAD, ST_ACTIVE, ST_TRAIL
    } phase_e;
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [BUS_AW-1:0] zone_off(input int i);
        return OFF_ZONE_BASE + ZONE_STRIDE * BUS_AW'(i);
    endfunction
    function automatic logic [ZONES-1:0] zone_onehot(
        input logic [ZIDX_W-1:0] z);
        return ZONES'(1) << z;
    endfunction
    function automatic logic [LEN_W-1:0] lead_len(
        input logic [CFG_W-1:0] c, input logic wr);
        logic [LEAD_W-1:0] l;
        l = wr ? c[WR_LEAD_LSB +: LEAD_W] : c[RD_LEAD_LSB +: LEAD_W];
        return LEN_W'(l) << c[DBL_BIT];
    endfunction
    function automatic logic [LEN_W-1:0] act_len(
        input logic [CFG_W-1:0] c, input logic wr);
        logic [ACT_W-1:0] a;
        a = wr ? c[WR_ACT_LSB +: ACT_W] : c[RD_ACT_LSB +: ACT_W];
        return (LEN_W'(a) << c[DBL_BIT]) + LEN_W'(1);
    endfunction
    function automatic logic [LEN_W-1:0] trail_len(
        input logic [CFG_W-1:0] c, input logic wr);
        logic [TRAIL_W-1:0] t;
        t = wr ? c[WR_TRAIL_LSB +: TRAIL_W] : c[RD_TRAIL_LSB +: TRAIL_W];
        return LEN_W'(t) << c[DBL_BIT];
    endfunction
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [CFG_W-1:0]  zone_cfg [ZONES];
    clk_mode_e         clk_mode;
    logic [CFG_W-1:0]  cur_cfg;
    logic              cur_write;
    logic [ZIDX_W-1:0] cur_zone;
    logic [XA_W-1:0]   cur_addr;
    phase_e            state;
    logic [LEN_W-1:0]  remaining;
    logic [WS_W-1:0]   ws_count;
    logic [LEN_W-1:0]  lead_n;
    logic [LEN_W-1:0]  act_n;
    logic [LEN_W-1:0]  trail_n;
    logic              rdy_en;
    logic              taken;
    logic              tick;
    logic              out_rise;
    logic              ready_s;
    logic [BUS_DW-1:0] next_rdata;
    assign taken   = acc_req && !acc_busy && (int'(acc_zone) < ZONES);
    assign rdy_en  = cur_cfg[RDY_EN_BIT];
    // settings are used as programmed; no range check is made
    assign lead_n  = lead_len(cur_cfg, cur_write);
    assign act_n   = act_len(cur_cfg, cur_write);
    assign trail_n = trail_len(cur_cfg, cur_write);
    // ------------------------------------------------------------
    // clocking and ready input
    // ------------------------------------------------------------
    clk_ratio_gen u_clk (
        .clk      (clk),
        .rst      (rst),
        .mode     (clk_mode),
        .tick     (tick),
        .out_rise (out_rise),
        .clk_out  (external_clock_output)
    );
    ready_sync u_rdy (
        .clk        (clk),
        .rst        (rst),
        .ready_pin  (external_ready_input),
        .async_mode (cur_cfg[RDY_ASYNC_BIT]),
        .ready_s    (ready_s)
    );
    // ------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------
    // a ratio change during an access can stretch or shrink its phases
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < ZONES; i++) begin
                zone_cfg[i] <= TIMING_RST;
            end
            clk_mode <= CLK_MODE_RST;
        end else if (reg_wr) begin
            for (int i = 0; i < ZONES; i++) begin
                if (reg_addr == zone_off(i)) begin
                    zone_cfg[i] <= reg_wdata[CFG_W-1:0];
                end
            end
            if (reg_addr == OFF_CLKCFG) begin
                clk_mode <= clk_mode_e'(reg_wdata[CLKCFG_W-1:0]);
            end
        end
    end

    // ------------------------------------------------------------
    // register reads
    // ------------------------------------------------------------
    always_comb begin
        next_rdata = '0;
        for (int i = 0; i < ZONES; i++) begin
            if (reg_addr == zone_off(i)) begin
                next_rdata = BUS_DW'(zone_cfg[i]);
            end
        end
        if (reg_addr == OFF_CLKCFG) begin
            next_rdata = BUS_DW'(clk_mode);
        end
        if (reg_addr == OFF_STATUS) begin
            next_rdata[ST_BUSY_BIT] = acc_busy;
            next_rdata[ST_PHASE_LSB +: 3] = 3'(state);
            next_rdata[ST_WS_LSB +: WS_W] = ws_count;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            reg_rdata <= '0;
        end else begin
            reg_rdata <= reg_rd ? next_rdata : '0;
        end
    end
    // ------------------------------------------------------------
    // access capture
    // ------------------------------------------------------------
    // snapshot keeps later zone register writes out of a running access
    always_ff @(posedge clk) begin
        if (rst) begin
            cur_cfg   <= TIMING_RST;
            cur_write <= 1'b0;
            cur_zone  <= '0;
            cur_addr  <= '0;
        end else if (taken) begin
            cur_cfg   <= zone_cfg[acc_zone];
            cur_write <= acc_write;
            cur_zone  <= acc_zone;
            cur_addr  <= acc_addr;
        end
    end
    // ------------------------------------------------------------
    // address pins
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            ext_addr <= '0;
        end else if (state == ST_ALIGN && tick && out_rise) begin
            ext_addr <= cur_addr;
        end
    end
    // ------------------------------------------------------------
    // phase sequencer and strobes
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            state          <= ST_IDLE;
            remaining      <= '0;
            ws_count       <= '0;
            acc_busy       <= 1'b0;
            acc_done       <= 1'b0;
            read_strobe_n  <= 1'b1;
            write_strobe_n <= 1'b1;
            zone_select_n  <= '1;
        end else begin
            acc_done <= 1'b0;
            unique case (state)
                ST_IDLE: begin
                    if (taken) begin
                        state    <= ST_ALIGN;
                        acc_busy <= 1'b1;
                        ws_count <= '0;
                    end
                end
                ST_ALIGN: begin
                    // strobes stay inactive until an output clock rise
                    if (tick && out_rise) begin
                        zone_select_n <= ~zone_onehot(cur_zone);
                        if (lead_n != '0) begin
                            state     <= ST_LEAD;
                            remaining <= lead_n;
                        end else begin
                            state          <= ST_ACTIVE;
                            remaining      <= act_n;
                            read_strobe_n  <= cur_write;
                            write_strobe_n <= !cur_write;
                        end
                    end
                end
                ST_LEAD: begin
                    if (tick) begin
                        if (remaining == LEN_W'(1)) begin
                            state          <= ST_ACTIVE;
                            remaining      <= act_n;
                            read_strobe_n  <= cur_write;
                            write_strobe_n <= !cur_write;
                        end else begin
                            remaining <= remaining - LEN_W'(1);
                        end
                    end
                end
                ST_ACTIVE: begin
                    if (tick) begin
                        if (remaining != LEN_W'(1)) begin
                            remaining <= remaining - LEN_W'(1);
                        end else if (rdy_en && !ready_s) begin
                            // hold in active; count one hardware wait
                            if (ws_count != '1) begin
                                ws_count <= ws_count + WS_W'(1);
                            end
                        end else begin
                            read_strobe_n  <= 1'b1;
                            write_strobe_n <= 1'b1;
                            if (trail_n != '0) begin
                                state     <= ST_TRAIL;
                                remaining <= trail_n;
                            end else begin
                                state         <= ST_IDLE;
                                zone_select_n <= '1;
                                acc_busy      <= 1'b0;
                                acc_done      <= 1'b1;
                            end
                        end
                    end
                end
                ST_TRAIL: begin
                    if (tick) begin
                        if (remaining == LEN_W'(1)) begin
                            state         <= ST_IDLE;
                            zone_select_n <= '1;
                            acc_busy      <= 1'b0;
                            acc_done      <= 1'b1;
                        end else begin
                            remaining <= remaining - LEN_W'(1);
                        end
                    end
                end
            endcase
        end
    end
    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    AST_PHASE_ORDER: assert property (
        @(posedge clk) disable iff (rst)
        state == ST_TRAIL && $past(state) != ST_TRAIL
        |-> $past(state) == ST_ACTIVE)
        else $error("trail entered from a phase other than active");
    AST_LEAD_LOAD: assert property (
        @(posedge clk) disable iff (rst)
        state == ST_LEAD && $past(state) != ST_LEAD
        |-> remaining == lead_n && lead_n != '0)
        else $error("lead phase loaded with wrong length");
    AST_ACTIVE_LOAD: assert property (
        @(posedge clk) disable iff (rst)
        state == ST_ACTIVE && $past(state) != ST_ACTIVE
        |-> remaining == act_n && ws_count == '0
            && read_strobe_n == cur_write)
        else $error("active phase loaded with wrong length");
    AST_TRAIL_LOAD: assert property (
        @(posedge clk) disable iff (rst)
        state == ST_TRAIL && $past(state) != ST_TRAIL
        |-> remaining == trail_n && read_strobe_n && write_strobe_n)
        else $error("trail phase loaded with wrong length");
    AST_TICK_ONLY: assert property (
        @(posedge clk) disable iff (rst)
        state != ST_IDLE && !tick |=> $stable(state) && $stable(remaining))
        else $error("phase counter moved without a timing tick");
    AST_NO_WAIT: assert property (
        @(posedge clk) disable iff (rst)
        state == ST_ACTIVE && !rdy_en |-> ws_count == '0)
        else $error("wait state counted with ready ignored");
    AST_READY_STALL: assert property (
        @(posedge clk) disable iff (rst)
        state == ST_ACTIVE && tick && remaining == LEN_W'(1) && rdy_en
        && !ready_s && ws_count != '1
        |=> state == ST_ACTIVE && ws_count == $past(ws_count) + WS_W'(1))
        else $error("ready low did not stretch the active phase");
    AST_STROBE_TICK: assert property (
        @(posedge clk) disable iff (rst)
        $changed({read_strobe_n, write_strobe_n, zone_select_n})
        |-> $past(tick))
        else $error("strobe changed between timing ticks");
    AST_LEAD_RISE: assert property (
        @(posedge clk) disable iff (rst)
        $past(state) == ST_ALIGN && state != ST_ALIGN
        |-> $past(tick) && $past(out_rise))
        else $error("access began off an output clock rise");
    AST_ALIGN_QUIET: assert property (
        @(posedge clk) disable iff (rst)
        state == ST_ALIGN |-> &zone_select_n && read_strobe_n
            && write_strobe_n)
        else $error("strobe active during alignment");
    AST_ADDR_HOLD: assert property (
        @(posedge clk) disable iff (rst)
        state inside {ST_IDLE, ST_ALIGN}
        && $past(state) inside {ST_IDLE, ST_ALIGN}
        |-> $stable(ext_addr))
        else $error("address changed while idle or aligning");
    AST_CFG_FROZEN: assert property (
        @(posedge clk) disable iff (rst)
        state != ST_IDLE && $past(state) != ST_IDLE |-> $stable(cur_cfg))
        else $error("zone settings changed during an access");
    AST_ZONE_SEL: assert property (
        @(posedge clk) disable iff (rst)
        state inside {ST_LEAD, ST_ACTIVE, ST_TRAIL}
        |-> zone_select_n == ~zone_onehot(cur_zone))
        else $error("wrong zone select during an access");
endmodule

/* ext_mem_dev_model.sv */
// Purpose: slow external device that answers strobes with a ready pin
// Assumes: ready line has a pull-up, so it reads high while unselected
// Notes:   ready low for wait_len cycles after each strobe fall
`timescale 1ns/1ns
module ext_mem_dev_model (
    // clock
    input  wire logic       clk,
    // device pins
    input  wire logic [2:0] zone_select_n,
    input  wire logic       read_strobe_n,
    input  wire logic       write_strobe_n,
    input  wire logic [3:0] wait_len,
    output logic            ready
);
    logic [3:0] cnt      = 4'h0;
    logic       strobe_d = 1'b1;
    // device is busy for a while once a strobe falls
    always @(posedge clk) begin
        strobe_d <= read_strobe_n & write_strobe_n;
        if (strobe_d && !(read_strobe_n & write_strobe_n))
            cnt <= wait_len;
        else if (cnt != 4'h0)
            cnt <= cnt - 4'h1;
    end
    // pull-up wins while no zone is selected
    assign ready = (&zone_select_n) | (cnt == 4'h0);
endmodule

/* tb.sv */
// Purpose: self-checking bench for the phase timing block
// Assumes: one access at a time, pins measured in clk cycles
// Notes:   slow ratio modes double every measured length
`timescale 1ns/1ns
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin num_errors++; \
 $display("mismatch %0t got %0h exp %0h", $time, g, e); end end
module tb;
    import ext_mem_pkg::*;
    typedef struct {
        int lead; int act; int trail; logic more; logic w;
        logic [2:0] zsel; logic [18:0] addr;
    } note_s;
    logic        clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0, reg_rdata;
    logic        acc_req = 1'b0, acc_write = 1'b0, acc_busy, acc_done;
    logic [1:0]  acc_zone = 2'h0;
    logic [18:0] acc_addr = 19'h0, ext_addr;
    logic        ready, xclk, rs_n, ws_n, rd_d = 1'b0;
    logic [2:0]  zs_n;
    logic [3:0]  wait_len = 4'h8;
    int          num_errors = 0, tests_run = 0, mult = 1, cl = 0, ca = 0, ct = 0;
    note_s       nq[$];
    logic [31:0] rq[$];
    logic [31:0] exp_rd;

    ext_mem_phase_timing u_dut (.clk(clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .acc_req(acc_req), .acc_write(acc_write),
        .acc_zone(acc_zone), .acc_addr(acc_addr), .acc_busy(acc_busy),
        .acc_done(acc_done), .external_ready_input(ready),
        .external_clock_output(xclk), .read_strobe_n(rs_n),
        .write_strobe_n(ws_n), .zone_select_n(zs_n), .ext_addr(ext_addr));
    ext_mem_dev_model u_dev (.clk(clk), .zone_select_n(zs_n),
        .read_strobe_n(rs_n), .write_strobe_n(ws_n), .wait_len(wait_len),
        .ready(ready));

    always #25 clk = ~clk;
    always @(posedge clk) rd_d <= reg_rd;

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        rq.push_back(e);
        @(posedge clk);
        reg_rd <= 1'b0;
    endtask
    function automatic logic [31:0] cfg(int l, a, t, re, ra, d);
        return 32'(l | a << WR_ACT_LSB | t << WR_TRAIL_LSB | re << RDY_EN_BIT
            | ra << RDY_ASYNC_BIT | l << RD_LEAD_LSB | a << RD_ACT_LSB
            | t << RD_TRAIL_LSB | d << DBL_BIT);
    endfunction
    // same counts for both directions, so w only picks the strobe
    task automatic acc(input int z, l, a, t, d, input logic w, more);
        note_s n;
        n = '{(l << d) * mult, ((a << d) + 1) * mult, (t << d) * mult, more,
            w, ~(3'h1 << z), 19'($urandom)};
        nq.push_back(n);
        @(posedge clk);
        acc_req <= 1'b1;
        acc_write <= w;
        acc_zone <= 2'(z);
        acc_addr <= n.addr;
        @(posedge clk);
        acc_req <= 1'b0;
        for (int i = 0; i < 400 && acc_done !== 1'b1; i++)
            @(negedge clk);
        `CHK(acc_done, 1'b1)
    endtask
    task automatic stop_test();
        $display("counts: %0d compares, %0d mismatches", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // ------------------------------------------------------------
    // monitor: measures phases on the pins, checks oldest note
    // ------------------------------------------------------------
    always @(negedge clk) begin
        if (rd_d === 1'b1) begin
            exp_rd = rq.pop_front();
            `CHK(reg_rdata, exp_rd)
        end
        if (nq.size() > 0) begin
            if (zs_n !== 3'h7 && cl == 0 && ca == 0)
                `CHK(xclk, 1'b1)
            if (rs_n === 1'b0 || ws_n === 1'b0) begin
                if (ca == 0)
                    `CHK({rs_n, ws_n, zs_n}, {nq[0].w, ~nq[0].w, nq[0].zsel})
                ca++;
            end else if (zs_n !== 3'h7) begin
                if (ca == 0)
                    cl++;
                else
                    ct++;
            end
            if (acc_done === 1'b1) begin
                `CHK(cl, nq[0].lead)
                if (nq[0].more)
                    `CHK(ca > nq[0].act, 1'b1)
                else
                    `CHK(ca, nq[0].act)
                `CHK(ct, nq[0].trail)
                `CHK(ext_addr, nq[0].addr)
                void'(nq.pop_front());
                cl = 0;
                ca = 0;
                ct = 0;
            end
        end
    end

    initial begin
        #3000000;
        num_errors++;
        stop_test();
    end

    initial begin
        int l, a, t, d, z;
        void'($urandom(32'h7bb64bc0));
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        rd(8'h00, 32'h1fe7f);
        rd(OFF_CLKCFG, 32'h2);
        wr(8'h14, 32'hffff);
        rd(8'h14, 32'h0);
        $display("test reset values done");
        wr(OFF_CLKCFG, 32'h1);
        for (int i = 0; i < 8; i++) begin
            {z, l, a, t, d} = {i % 3, 1 + $urandom_range(2), $urandom_range(7),
                $urandom_range(3), $urandom_range(1)};
            wr(8'(z * 4), cfg(l, a, t, 0, 0, d));
            acc(z, l, a, t, d, 1'($urandom), 1'b0);
        end
        $display("test phase lengths done");
        wr(8'h00, cfg(0, 0, 0, 0, 0, 0));
        acc(0, 0, 0, 0, 0, 1'b0, 1'b0);
        wr(8'h04, cfg(1, 2, 1, 0, 0, 0));
        fork
            acc(1, 1, 2, 1, 0, 1'b1, 1'b0);
            begin
                repeat (3) @(posedge clk);
                wr(8'h04, cfg(3, 4, 2, 0, 0, 1));
            end
        join
        acc(1, 3, 4, 2, 1, 1'b0, 1'b0);
        $display("test settings in flight done");
        wr(8'h08, cfg(1, 5, 0, 0, 0, 0));
        acc(2, 1, 5, 0, 0, 1'b0, 1'b0);
        rd(OFF_STATUS, 32'h0);
        wr(8'h08, cfg(1, 5, 0, 1, 0, 0));
        acc(2, 1, 5, 0, 0, 1'b1, 1'b1);
        wr(8'h08, cfg(2, 5, 0, 1, 1, 0));
        acc(2, 2, 5, 0, 0, 1'b0, 1'b1);
        $display("test ready done");
        for (int m = 0; m < 4; m++) begin
            wr(OFF_CLKCFG, 32'(m));
            mult = (m >= 2) ? 2 : 1;
            acc(0, 0, 0, 0, 0, 1'b1, 1'b0);
        end
        $display("test clock ratios done");
        @(posedge clk);
        acc_req <= 1'b1;
        acc_zone <= 2'h3;
        @(posedge clk);
        acc_req <= 1'b0;
        repeat (10) @(negedge clk);
        `CHK(acc_busy, 1'b0)
        `CHK(nq.size(), 0)
        $display("test refused zone done");
        stop_test();
    end
endmodule
